// ==== crd_top.v ====
// Processor clock ratio divider with fast RC postscaler select.
// Assumes interrupt and oscillator select inputs come from mclk logic.
//
// Notes on behaviour
// RL1: Recovery bit: interrupt clears enable, ratio 1:1.
// RL2: Recovery bit clear: interrupts change nothing.
// RL3: Codes 111/110/101 give 1:128, 1:64, 1:32.
// RL4: Code 000 gives ratio 1:1.
// RL5: Enable set applies selected ratio.
// RL6: Enable clear forces 1:1 ratio.
// RL7: Postscaler applies when oscillator select is 111.
// RL8: Unimplemented bits read zero, ignore writes.
// RL9: Codes 100/011/010/001 give 1:16 to 1:2.
// RL10: Processor enable one cycle in N.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`include "crd_map.vh"
`default_nettype none

module crd_top (
    input wire mclk,
    input wire arst_n,
    input wire [`CRD_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire intr_req,
    input wire [2:0] current_oscillator_select,
    output reg cpu_clk_en,
    output reg periph_clk_en,
    output reg ratio_active,
    output reg internal_fast_rc_clock_en,
    output reg [2:0] fast_rc_postscale_select_out
);

    // Control register fields
    reg recover_on_interrupt;
    reg [2:0] ratio_select;
    reg ratio_enable;
    reg [2:0] fast_rc_postscale_select;

    // Recovery event counter
    reg [7:0] recover_count;

    // Next values
    reg next_recover_on_interrupt;
    reg [2:0] next_ratio_select;
    reg next_ratio_enable;
    reg [2:0] next_fast_rc_postscale_select;
    reg [7:0] next_recover_count;
    reg [15:0] next_rdata;

    // Decode
    wire wr_ctrl;
    wire wr_rcnt;
    wire rd_ctrl;
    wire rd_stat;
    wire rd_rcnt;
    wire [15:0] wdata_masked;
    wire recover_now;

    // Ratio and postscaler datapath
    reg [3:0] cpu_shift;
    reg [3:0] frc_shift;
    wire cpu_run;
    wire frc_run;
    wire cpu_tick;
    wire frc_tick;
    wire [15:0] ctrl_view;
    wire [15:0] stat_view;

    assign wr_ctrl = reg_wr && (reg_addr == `CRD_OFS_CTRL);
    assign wr_rcnt = reg_wr && (reg_addr == `CRD_OFS_RCNT);
    assign rd_ctrl = reg_rd && (reg_addr == `CRD_OFS_CTRL);
    assign rd_stat = reg_rd && (reg_addr == `CRD_OFS_STAT);
    assign rd_rcnt = reg_rd && (reg_addr == `CRD_OFS_RCNT);

    // RL8 mask unimplemented bits
    assign wdata_masked = reg_wdata & `CRD_CTRL_WMASK;

    // RL1 recovery only with bit set
    assign recover_now = intr_req && recover_on_interrupt;

    // Recover-on-interrupt bit, software owned
    always @* begin
        next_recover_on_interrupt = recover_on_interrupt;
        if (wr_ctrl) begin
            next_recover_on_interrupt = wdata_masked[`CRD_ROI_BIT];
        end
    end

    // Ratio select field, software owned
    always @* begin
        next_ratio_select = ratio_select;
        if (wr_ctrl) begin
            next_ratio_select = wdata_masked[`CRD_DOZE_HI:`CRD_DOZE_LO];
        end
    end

    // Ratio enable: software sets, interrupt recovery clears
    always @* begin
        // RL2 hold unless written
        next_ratio_enable = ratio_enable;
        if (wr_ctrl) begin
            next_ratio_enable = wdata_masked[`CRD_RATIO_ENABLE_BIT];
        end
        // RL1 interrupt clears enable
        if (recover_now) begin
            next_ratio_enable = 1'b0;
        end
    end

    // Fast RC postscaler field
    always @* begin
        next_fast_rc_postscale_select = fast_rc_postscale_select;
        if (wr_ctrl) begin
            next_fast_rc_postscale_select = wdata_masked[`CRD_FAST_RC_POSTSCALE_SELECT_HI:`CRD_FAST_RC_POSTSCALE_SELECT_LO];
        end
    end

    // Counts recoveries; a write clears, an event in the same cycle wins unless the count is 8'hFF
    always @* begin
        next_recover_count = recover_count;
        if (wr_rcnt) begin
            next_recover_count = 8'h00;
        end
        if (recover_now && recover_count != 8'hFF) begin
            if (wr_rcnt) begin
                next_recover_count = 8'h01;
            end else begin
                next_recover_count = recover_count + 8'h01;
            end
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            recover_on_interrupt <= `CRD_ROI_RST;
            ratio_select <= 3'h0;
            ratio_enable <= 1'b0;
            fast_rc_postscale_select <= 3'h0;
            recover_count <= 8'h00;
        end else begin
            recover_on_interrupt <= next_recover_on_interrupt;
            ratio_select <= next_ratio_select;
            ratio_enable <= next_ratio_enable;
            fast_rc_postscale_select <= next_fast_rc_postscale_select;
            recover_count <= next_recover_count;
        end
    end

    // Processor ratio shift from field and enable
    always @* begin
        cpu_shift = 4'h0;
        // RL5 apply selected ratio
        if (ratio_enable) begin
            case (ratio_select)
                // RL4 code 000 is 1:1
                3'h0: cpu_shift = 4'h0;
                // RL9 codes 001 to 100
                3'h1: cpu_shift = 4'h1;
                3'h2: cpu_shift = 4'h2;
                3'h3: cpu_shift = 4'h3;
                3'h4: cpu_shift = 4'h4;
                // RL3 codes 101 to 111
                3'h5: cpu_shift = 4'h5;
                3'h6: cpu_shift = 4'h6;
                3'h7: cpu_shift = 4'h7;
                default: cpu_shift = 4'h0;
            endcase
        end
        // RL6 disabled means 1:1
    end

    // Fast RC postscaler shift
    always @* begin
        case (fast_rc_postscale_select)
            3'h0: frc_shift = `CRD_FRC_SH0;
            3'h1: frc_shift = `CRD_FRC_SH1;
            3'h2: frc_shift = `CRD_FRC_SH2;
            3'h3: frc_shift = `CRD_FRC_SH3;
            3'h4: frc_shift = `CRD_FRC_SH4;
            3'h5: frc_shift = `CRD_FRC_SH5;
            3'h6: frc_shift = `CRD_FRC_SH6;
            // RL7 code 111 divides by 256
            3'h7: frc_shift = `CRD_FRC_SH7;
            default: frc_shift = 4'h0;
        endcase
    end

    assign cpu_run = (cpu_shift != 4'h0);

    // RL7 only with fast RC selected
    assign frc_run = (current_oscillator_select == `CRD_CURRENT_OSCILLATOR_SELECT_FRC) && (frc_shift != 4'h0);

    // RL10 processor enable one in N
    crd_pow2_tick u_cpu_tick (
        .mclk(mclk),
        .arst_n(arst_n),
        .run(cpu_run),
        .shift(cpu_shift),
        .tick(cpu_tick)
    );

    // Fast RC postscaled enable
    crd_pow2_tick u_frc_tick (
        .mclk(mclk),
        .arst_n(arst_n),
        .run(frc_run),
        .shift(frc_shift),
        .tick(frc_tick)
    );

    // Register views, unimplemented bits zero
    assign ctrl_view = {recover_on_interrupt, ratio_select, ratio_enable,
                        fast_rc_postscale_select, 8'h00};
    assign stat_view = {4'h0, frc_shift, 2'h0, frc_run, cpu_run, cpu_shift};

    // RL8 unmapped and reserved read zero
    always @* begin
        next_rdata = 16'h0000;
        if (rd_ctrl) begin
            next_rdata = ctrl_view;
        end else if (rd_stat) begin
            next_rdata = stat_view;
        end else if (rd_rcnt) begin
            next_rdata = {8'h00, recover_count};
        end
    end

    // Registered outputs
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            ratio_active <= 1'b0;
            internal_fast_rc_clock_en <= 1'b0;
            fast_rc_postscale_select_out <= 3'h0;
        end else begin
            reg_rdata <= next_rdata;
            // RL10 peripherals stay at full rate
            cpu_clk_en <= cpu_tick;
            periph_clk_en <= 1'b1;
            ratio_active <= cpu_run;
            internal_fast_rc_clock_en <= frc_tick;
            fast_rc_postscale_select_out <= fast_rc_postscale_select;
        end
    end

endmodule // crd_top

`default_nettype wire

// ==== crd_map.vh ====
// Register map and constants of the processor clock ratio divider.
// Included by the divider top and its tick generator; definitions only.
`ifndef CRD_MAP_VH
`define CRD_MAP_VH

// Register indices on the plain register port
`define CRD_ADDR_W 4
`define CRD_OFS_CTRL 4'h0
`define CRD_OFS_STAT 4'h1
`define CRD_OFS_RCNT 4'h2

// Control register fields
`define CRD_ROI_BIT 15
`define CRD_DOZE_HI 14
`define CRD_DOZE_LO 12
`define CRD_RATIO_ENABLE_BIT 11
`define CRD_FAST_RC_POSTSCALE_SELECT_HI 10
`define CRD_FAST_RC_POSTSCALE_SELECT_LO 8

// Reset value and writable bits of the control register
`define CRD_CTRL_RST 16'h0000
`define CRD_CTRL_WMASK 16'hFF00
`define CRD_ROI_RST 1'b0

// Status register fields
`define CRD_STAT_SHIFT_HI 3
`define CRD_STAT_SHIFT_LO 0
`define CRD_STAT_ACTIVE_BIT 4
`define CRD_STAT_FRC_BIT 5
`define CRD_STAT_FSHIFT_HI 11
`define CRD_STAT_FSHIFT_LO 8

// Oscillator select code that routes the fast RC postscaler
`define CRD_CURRENT_OSCILLATOR_SELECT_FRC 3'h7

// Fast RC postscaler: power-of-two shift per code
`define CRD_FRC_SH0 4'h0
`define CRD_FRC_SH1 4'h1
`define CRD_FRC_SH2 4'h2
`define CRD_FRC_SH3 4'h3
`define CRD_FRC_SH4 4'h4
`define CRD_FRC_SH5 4'h5
`define CRD_FRC_SH6 4'h6
`define CRD_FRC_SH7 4'h8

// Tick counter width (covers divide-by-256)
`define CRD_CNT_W 8

`endif

// ==== crd_pow2_tick.v ====
// Power-of-two tick generator: one pulse every 2^shift clocks.
// Assumes shift of at most 8 and a single clock domain.
`include "crd_map.vh"
`default_nettype none

module crd_pow2_tick (
    input wire mclk,
    input wire arst_n,
    input wire run,
    input wire [3:0] shift,
    output reg tick
);

    wire [8:0] span;
    wire [8:0] span_m1;
    wire [`CRD_CNT_W-1:0] limit;
    wire wrap;
    reg [`CRD_CNT_W-1:0] cnt;
    reg [3:0] shift_q;
    reg [`CRD_CNT_W-1:0] next_cnt;

    assign span = 9'h001 << shift;
    assign span_m1 = span - 9'h001;
    assign limit = span_m1[`CRD_CNT_W-1:0];
    assign wrap = (cnt >= limit);

    // Restart the phase on any change of ratio
    always @* begin
        if (!run || shift != shift_q || wrap) begin
            next_cnt = {`CRD_CNT_W{1'b0}};
        end else begin
            next_cnt = cnt + 8'h01;
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            shift_q <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            shift_q <= shift;
            tick <= !run || (wrap && shift == shift_q);
        end
    end

endmodule // crd_pow2_tick

`default_nettype wire

// ==== crd_top_assertions.sv ====
// Concurrent checks on the clock ratio divider top ports.
// Assumes it is bound to crd_top and sees only its ports.
`include "crd_map.vh"
`default_nettype none
module crd_top_assertions (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [`CRD_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic intr_req,
    input wire logic [2:0] current_oscillator_select,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic ratio_active,
    input wire logic internal_fast_rc_clock_en,
    input wire logic [2:0] fast_rc_postscale_select_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic roi_q;
    logic wc;
    logic [1:0] up_cnt;
    // Cycles since reset release, saturating
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    end
    assign wc = reg_wr && reg_addr == `CRD_OFS_CTRL;
    // Shadow of the recovery bit
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            roi_q <= 1'b0;
        else if (wc)
            roi_q <= reg_wdata[15];
    end
    a_low_byte: assert property ($past(reg_rd && reg_addr == 4'h0) |-> reg_rdata[7:0] == 8'h00)
        else $error("ctrl low byte not zero");
    a_periph_full: assert property ($past(arst_n) |-> periph_clk_en)
        else $error("peripheral enable dropped");
    a_full_rate: assert property (!ratio_active [*4] ##1 !ratio_active [*3]
        |-> $past(cpu_clk_en, 3))
        else $error("cpu enable gap at full rate");
    a_sparse_tick: assert property (ratio_active [*6] ##0 cpu_clk_en ##1 ratio_active [*2]
        |-> $past(!cpu_clk_en))
        else $error("cpu enable on two cycles in a row");
    a_frc_idle: assert property (up_cnt == 2'h3 ##0 (current_oscillator_select != 3'h7) [*3]
        |-> internal_fast_rc_clock_en)
        else $error("fast rc enable low off fast rc");
    a_sel_copy: assert property (wc ##1 !wc |=> fast_rc_postscale_select_out
        == $past(reg_wdata[10:8], 2))
        else $error("postscale select copy wrong");
    a_ratio_on: assert property (wc && reg_wdata[11] && reg_wdata[14:12] != 3'h0 && !intr_req
        ##1 !reg_wr && !intr_req |=> ratio_active)
        else $error("ratio not applied");
    a_ratio_off: assert property (wc && (!reg_wdata[11] || reg_wdata[14:12] == 3'h0)
        ##1 !reg_wr |=> !ratio_active)
        else $error("ratio active at 1:1");
    a_roi_clear: assert property (roi_q && intr_req ##1 !reg_wr |=> !ratio_active)
        else $error("interrupt did not recover");
    a_roi_hold: assert property (!roi_q && intr_req && !reg_wr && !$past(reg_wr)
        ##1 !reg_wr |=> $stable(ratio_active))
        else $error("interrupt changed ratio");
endmodule // crd_top_assertions
bind crd_top crd_top_assertions crd_top_assertions_i (.mclk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .intr_req, .current_oscillator_select, .cpu_clk_en,
    .periph_clk_en, .ratio_active, .internal_fast_rc_clock_en, .fast_rc_postscale_select_out);
`default_nettype wire

// ==== crd_top_test.sv ====
// Self-checking bench for the clock ratio divider top.
// Assumes crd_top alone; the bench drives every input itself.
`include "crd_map.vh"
`default_nettype none
module crd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, arst_n, reg_wr, reg_rd, intr_req, cpu_clk_en, periph_clk_en;
    logic ratio_active, internal_fast_rc_clock_en;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] current_oscillator_select, fast_rc_postscale_select_out;
    int miscompares = 0;
    int compares = 0;
    crd_top crd_top_i (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .intr_req, .current_oscillator_select, .cpu_clk_en, .periph_clk_en, .ratio_active,
        .internal_fast_rc_clock_en, .fast_rc_postscale_select_out);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic finish_test();
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(nm, exp, reg_rdata);
    endtask
    task automatic pulse();
        intr_req <= 1'b1;
        @(posedge mclk);
        intr_req <= 1'b0;
    endtask
    // Cycles between the second and third enable pulse
    task automatic gap(input bit internal_fast_rc_clock, input logic [15:0] exp, input string nm);
        int n = 0;
        int k = 0;
        for (int i = 0; i < 1200 && k < 3; i++) begin
            @(posedge mclk);
            #1;
            if ((internal_fast_rc_clock ? internal_fast_rc_clock_en : cpu_clk_en) === 1'b1) begin
                k++;
                n = (k < 3) ? 0 : n;
            end else begin
                n++;
            end
        end
        chk(nm, exp, 16'(n + 1));
        if (k < 3) begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic t_regs();
        rd(4'h0, 16'h0000, "ctrl reset");
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hFF00, "ctrl");
        wr(4'h1, 16'hFFFF);
        rd(4'hF, 16'h0000, "unmapped");
    endtask
    task automatic t_ratios();
        for (int c = 1; c < 8; c++) begin
            wr(4'h0, 16'h0000);
            wr(4'h0, {1'b0, c[2:0], 12'h800});
            gap(1'b0, 16'h0001 << c, "cpu gap");
            chk("periph en", 16'h0001, {15'h0, periph_clk_en});
        end
        wr(4'h0, 16'h0800);
        gap(1'b0, 16'h0001, "cpu gap");
        wr(4'h0, 16'h7000);
        gap(1'b0, 16'h0001, "cpu gap");
    endtask
    task automatic t_recover();
        wr(4'h0, 16'hF800);
        pulse();
        rd(4'h0, 16'hF000, "ctrl");
        gap(1'b0, 16'h0001, "cpu gap");
        wr(4'h0, 16'h7800);
        @(posedge mclk);
        pulse();
        rd(4'h0, 16'h7800, "ctrl");
        chk("active", 16'h0001, {15'h0, ratio_active});
        rd(4'h2, 16'h0001, "rcnt");
        rd(4'h1, 16'h0017, "status");
        wr(4'h2, 16'h0000);
        rd(4'h2, 16'h0000, "rcnt clear");
    endtask
    task automatic t_frc();
        current_oscillator_select <= 3'h7;
        wr(4'h0, 16'h0700);
        @(posedge mclk);
        #1 chk("frc sel", 16'h0007, {13'h0, fast_rc_postscale_select_out});
        rd(4'h1, 16'h0820, "status");
        gap(1'b1, 16'h0100, "frc gap");
        current_oscillator_select <= 3'h0;
        gap(1'b1, 16'h0001, "frc gap");
    endtask
    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        intr_req = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        current_oscillator_select = 3'h0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_ratios();
        t_recover();
        t_frc();
        finish_test();
    end
endmodule // crd_top_test
`default_nettype wire
